// >>> gamma_pkg.sv
// Package of index addresses, field positions, reset values and modes for the gamma table access block
package gamma_pkg;

  // Index addresses, page bit included as the top bit
  localparam logic [8:0] IDX_CTRL = 9'h0f0; // Gamma control register
  localparam logic [8:0] IDX_TADDR = 9'h0f1; // Table address port
  localparam logic [8:0] IDX_TDATA = 9'h0f2; // Table data port
  localparam logic [7:0] IDX_PAGE_LOW = 8'hff; // Page select, seen at index_page_select and 0x1ff

  // Field positions inside the gamma control register
  localparam int CTRL_RED_BIT = 7; // Red correction enable
  localparam int CTRL_GREEN_BIT = 6; // Green correction enable
  localparam int CTRL_BLUE_BIT = 5; // Blue correction enable
  localparam int CTRL_INC_LSB = 2; // Auto-increment field, bits 3-2
  localparam int CTRL_SEL_LSB = 0; // Table selection field, bits 1-0
  localparam logic [7:0] CTRL_STORE_MASK = 8'hef; // Bit 4 is reserved, reads zero

  // Field position of the page bit
  localparam int PAGE_BIT = 0; // Page select bit

  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00; // All corrections off, no increment, RGB set
  localparam logic [7:0] TADDR_RESET = 8'h00; // Table address port
  localparam logic PAGE_RESET = 1'b0; // Low page
  localparam logic [7:0] INDEX_RESET = 8'h00; // Serial index address
  localparam logic [7:0] RDATA_RESET = 8'h00; // Read data register
  localparam logic [7:0] UNMAPPED_READ = 8'h00; // Answer for an index nobody owns

  // Table geometry
  localparam int TABLE_AW = 8; // Entries are addressed by one byte
  localparam int TABLE_DW = 8; // Each entry is one byte
  localparam int TABLE_DEPTH = 256; // Entries per colour table

  // Table selection field
  typedef enum logic [1:0]
  {
    SEL_RGB = 2'b00,
    SEL_RED = 2'b01,
    SEL_GREEN = 2'b10,
    SEL_BLUE = 2'b11
  } table_sel_e;

  // Auto-increment field
  typedef enum logic [1:0]
  {
    INC_NONE = 2'b00,
    INC_READ = 2'b01,
    INC_WRITE = 2'b10,
    INC_BOTH = 2'b11
  } inc_mode_e;

endpackage : gamma_pkg

// >>> gamma_ram_if.sv
// Interface joining the control logic to one colour table
`timescale 1ns/1ps
interface gamma_ram_if;
  import gamma_pkg::*;
  logic [TABLE_AW-1:0] host_addr; // Entry reached through the data port
  logic [TABLE_DW-1:0] wdata; // Byte to store
  logic we; // Store strobe
  logic [TABLE_DW-1:0] host_rdata; // Entry at host_addr
  logic [TABLE_AW-1:0] pix_addr; // Pixel value used as lookup address
  logic [TABLE_DW-1:0] pix_rdata; // Corrected pixel value

  // Table side
  modport table_side
  (
    input host_addr,
    input wdata,
    input we,
    input pix_addr,
    output host_rdata,
    output pix_rdata
  );

  // Control side
  modport ctrl_side
  (
    output host_addr,
    output wdata,
    output we,
    output pix_addr,
    input host_rdata,
    input pix_rdata
  );
endinterface : gamma_ram_if

// >>> gamma_table_ram.sv
// One colour gamma table with a write port and two read ports
`timescale 1ns/1ps
module gamma_table_ram
  import gamma_pkg::*;
(
  input wire logic clock, // Register clock
  gamma_ram_if.table_side port // Table access signals
);

  // Table storage, no reset value
  logic [TABLE_DW-1:0] mem [TABLE_DEPTH];

  // Store a byte on the write strobe
  always_ff @(posedge clock)
  begin
    if (port.we)
    begin
      mem[port.host_addr] <= port.wdata;
    end
  end

  // Host read and pixel lookup are both immediate
  assign port.host_rdata = mem[port.host_addr];
  assign port.pix_rdata = mem[port.pix_addr];

endmodule : gamma_table_ram

// >>> gamma_table_access.sv
// Gamma control, indirect table access and pixel correction
//
// Behaviour
// - Red, green, blue corrections enabled separately, off after reset
// - Auto-increment field steps address per data access
// - Increment modes: none, read, write, both
// - Selection field picks RGB, red, green, blue
// - Tables share address port and data port
// - Address port is eight bits, resets zero
// - Data port writes or reads selected entry
// - Page bit at index_page_select/0x1ff picks index page
// - Index advances per byte unless disabled
`timescale 1ns/1ps
module gamma_table_access
  import gamma_pkg::*;
(
  input wire logic clock, // Register clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic xfer_start, // Pulse, opens a serial transfer
  input wire logic [7:0] xfer_index, // Start index of the transfer
  input wire logic byte_write, // Pulse, one written byte
  input wire logic byte_read, // Pulse, one read byte
  input wire logic [7:0] write_data, // Written byte
  input wire logic index_inc_disable, // Holds index fixed during a transfer
  output logic [7:0] read_data, // Read byte, registered
  output logic read_valid, // Pulse, read_data is fresh
  input wire logic pix_valid, // Pixel strobe
  input wire logic [7:0] pix_red, // Red pixel in
  input wire logic [7:0] pix_green, // Green pixel in
  input wire logic [7:0] pix_blue, // Blue pixel in
  output logic pix_out_valid, // Corrected pixel strobe
  output logic [7:0] pix_out_red, // Red pixel out
  output logic [7:0] pix_out_green, // Green pixel out
  output logic [7:0] pix_out_blue // Blue pixel out
);

  // Register state
  logic [7:0] ctrl_reg; // Gamma control
  logic [7:0] taddr_reg; // Table address port
  logic page_reg; // Index page select
  logic [7:0] index_reg; // Serial index address
  logic [7:0] rdata_reg; // Read data
  logic rvalid_reg; // Read data strobe
  logic [7:0] rdata_next; // Read mux output

  // Pixel outputs
  logic pvalid_reg; // Pixel strobe out
  logic [7:0] pred_reg; // Red out
  logic [7:0] pgreen_reg; // Green out
  logic [7:0] pblue_reg; // Blue out

  // Decoded access
  logic wr; // Accepted byte write
  logic rd; // Accepted byte read
  logic [8:0] eff_index; // Page and index together
  logic hit_ctrl; // Control register addressed
  logic hit_taddr; // Address port addressed
  logic hit_tdata; // Data port addressed
  logic hit_page; // Page register addressed
  table_sel_e sel; // Current table selection
  inc_mode_e inc; // Current increment mode
  logic inc_on_rd; // Step address after a data read
  logic inc_on_wr; // Step address after a data write

  // One interface per colour table
  gamma_ram_if red_if ();
  gamma_ram_if green_if ();
  gamma_ram_if blue_if ();

  // Colour tables
  gamma_table_ram red_ram
  (
    .clock(clock),
    .port(red_if.table_side)
  );
  gamma_table_ram green_ram
  (
    .clock(clock),
    .port(green_if.table_side)
  );
  gamma_table_ram blue_ram
  (
    .clock(clock),
    .port(blue_if.table_side)
  );

  // Strobes: a start wins over a byte, a write over a read
  assign wr = byte_write && !xfer_start;
  assign rd = byte_read && !byte_write && !xfer_start;

  // Index decode with page bit on top
  assign eff_index = {page_reg, index_reg};
  assign hit_ctrl = (eff_index == IDX_CTRL);
  assign hit_taddr = (eff_index == IDX_TADDR);
  assign hit_tdata = (eff_index == IDX_TDATA);
  assign hit_page = (index_reg == IDX_PAGE_LOW);

  // Control fields
  assign sel = table_sel_e'(ctrl_reg[CTRL_SEL_LSB +: 2]);
  assign inc = inc_mode_e'(ctrl_reg[CTRL_INC_LSB +: 2]);
  assign inc_on_rd = (inc == INC_READ) || (inc == INC_BOTH);
  assign inc_on_wr = (inc == INC_WRITE) || (inc == INC_BOTH);

  // Shared address and data to every table
  assign red_if.host_addr = taddr_reg;
  assign green_if.host_addr = taddr_reg;
  assign blue_if.host_addr = taddr_reg;
  assign red_if.wdata = write_data;
  assign green_if.wdata = write_data;
  assign blue_if.wdata = write_data;

  // Write strobes: the RGB set stores into all three
  assign red_if.we = wr && hit_tdata && (sel == SEL_RGB || sel == SEL_RED);
  assign green_if.we = wr && hit_tdata && (sel == SEL_RGB || sel == SEL_GREEN);
  assign blue_if.we = wr && hit_tdata && (sel == SEL_RGB || sel == SEL_BLUE);

  // Pixel lookups
  assign red_if.pix_addr = pix_red;
  assign green_if.pix_addr = pix_green;
  assign blue_if.pix_addr = pix_blue;

  // Serial index: loaded at start, stepped per byte unless held
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      index_reg <= INDEX_RESET;
    end
    else if (xfer_start)
    begin
      index_reg <= xfer_index;
    end
    else if ((wr || rd) && !index_inc_disable)
    begin
      index_reg <= index_reg + 8'h01;
    end
  end

  // Page select, reachable from either page
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      page_reg <= PAGE_RESET;
    end
    else if (wr && hit_page)
    begin
      page_reg <= write_data[PAGE_BIT];
    end
  end

  // Gamma control, reserved bit never stored
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else if (wr && hit_ctrl)
    begin
      ctrl_reg <= write_data & CTRL_STORE_MASK;
    end
  end

  // Table address: loaded by its port, stepped by data accesses
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      taddr_reg <= TADDR_RESET;
    end
    else if (wr && hit_taddr)
    begin
      taddr_reg <= write_data;
    end
    else if ((wr && hit_tdata && inc_on_wr) || (rd && hit_tdata && inc_on_rd))
    begin
      taddr_reg <= taddr_reg + 8'h01;
    end
  end

  // Read mux; the RGB set answers with the red entry
  always_comb
  begin
    rdata_next = UNMAPPED_READ;
    if (hit_ctrl)
    begin
      rdata_next = ctrl_reg;
    end
    else if (hit_taddr)
    begin
      rdata_next = taddr_reg;
    end
    else if (hit_tdata)
    begin
      case (sel)
        SEL_RGB: rdata_next = red_if.host_rdata;
        SEL_RED: rdata_next = red_if.host_rdata;
        SEL_GREEN: rdata_next = green_if.host_rdata;
        SEL_BLUE: rdata_next = blue_if.host_rdata;
        default: rdata_next = UNMAPPED_READ;
      endcase
    end
    else if (hit_page)
    begin
      rdata_next = {7'h00, page_reg};
    end
  end

  // Read data capture
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      rdata_reg <= RDATA_RESET;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= rd;
      if (rd)
      begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Pixel correction, each colour on its own enable
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pvalid_reg <= 1'b0;
      pred_reg <= 8'h00;
      pgreen_reg <= 8'h00;
      pblue_reg <= 8'h00;
    end
    else
    begin
      pvalid_reg <= pix_valid;
      if (pix_valid)
      begin
        pred_reg <= ctrl_reg[CTRL_RED_BIT] ? red_if.pix_rdata : pix_red;
        pgreen_reg <= ctrl_reg[CTRL_GREEN_BIT] ? green_if.pix_rdata : pix_green;
        pblue_reg <= ctrl_reg[CTRL_BLUE_BIT] ? blue_if.pix_rdata : pix_blue;
      end
    end
  end

  // Outputs
  assign read_data = rdata_reg;
  assign read_valid = rvalid_reg;
  assign pix_out_valid = pvalid_reg;
  assign pix_out_red = pred_reg;
  assign pix_out_green = pgreen_reg;
  assign pix_out_blue = pblue_reg;

  // Red bypass when its correction is off
  a_red_bypass: assert property (@(posedge clock) disable iff (!resetn)
    pix_valid && !ctrl_reg[CTRL_RED_BIT] |=> pix_out_valid && pix_out_red == $past(pix_red))
    else $error("red pixel not passed through");

  // Write increment steps the address
  a_write_step: assert property (@(posedge clock) disable iff (!resetn)
    wr && hit_tdata && inc_on_wr |=> taddr_reg == $past(taddr_reg) + 8'h01)
    else $error("table address did not step after write");

  // Read without read increment leaves address alone
  a_read_hold: assert property (@(posedge clock) disable iff (!resetn)
    rd && hit_tdata && !inc_on_rd |=> $stable(taddr_reg))
    else $error("table address moved on read");

  // Green selection reads the green table
  a_green_read: assert property (@(posedge clock) disable iff (!resetn)
    rd && hit_tdata && sel == SEL_GREEN |=> read_valid && read_data == $past(green_if.host_rdata))
    else $error("green entry not returned");

  // Address port write loads the address
  a_addr_load: assert property (@(posedge clock) disable iff (!resetn)
    wr && hit_taddr |=> taddr_reg == $past(write_data))
    else $error("address port not loaded");

  // RGB selection writes all tables
  a_rgb_write: assert property (@(posedge clock) disable iff (!resetn)
    wr && hit_tdata && sel == SEL_RGB |=> red_ram.mem[$past(taddr_reg)] == $past(write_data)
      && green_ram.mem[$past(taddr_reg)] == $past(write_data) && blue_ram.mem[$past(taddr_reg)] == $past(write_data))
    else $error("RGB write missed a table");

  // Page bit follows its write
  a_page_load: assert property (@(posedge clock) disable iff (!resetn)
    wr && hit_page |=> page_reg == $past(write_data[PAGE_BIT]))
    else $error("page bit not loaded");

  // Index steps per byte, or stays when held
  a_index_step: assert property (@(posedge clock) disable iff (!resetn)
    (wr || rd) |=> index_reg == ($past(index_inc_disable) ? $past(index_reg) : $past(index_reg) + 8'h01))
    else $error("serial index step wrong");

  // Corrections off after reset
  a_reset_off: assert property (@(posedge clock)
    !resetn |=> ctrl_reg == CTRL_RESET && taddr_reg == TADDR_RESET)
    else $error("reset values wrong");

endmodule : gamma_table_access

// >>> host_serial_model.sv
// Behavioural host driving the serial register port of the gamma block
`timescale 1ns/1ps
module host_serial_model
(
  input wire logic clock, // Register clock
  output logic xfer_start, // Transfer open pulse
  output logic [7:0] xfer_index, // Start index
  output logic byte_write, // Write byte pulse
  output logic byte_read, // Read byte pulse
  output logic [7:0] write_data, // Written byte
  output logic index_inc_disable, // Holds index fixed
  input wire logic [7:0] read_data, // Read byte
  input wire logic read_valid // Read byte fresh
);
  // Idle port at time zero
  initial
  begin
    xfer_start = 1'b0;
    xfer_index = 8'h00;
    byte_write = 1'b0;
    byte_read = 1'b0;
    write_data = 8'h00;
    index_inc_disable = 1'b1;
  end

  // Open a transfer; the start index is driven with the one-cycle start pulse
  task automatic open_xfer(input logic [7:0] idx);
    @(negedge clock);
    xfer_start = 1'b1;
    xfer_index = idx;
    @(negedge clock);
    xfer_start = 1'b0;
    xfer_index = ~idx; // Stale index is not left on the bus
  endtask : open_xfer

  // Send one byte at the current index
  task automatic send_byte(input logic [7:0] d);
    @(negedge clock);
    byte_write = 1'b1;
    write_data = d;
    @(negedge clock);
    byte_write = 1'b0;
    write_data = ~d; // Released data no longer shows the byte
  endtask : send_byte

  // Hold or free the serial index for the bytes that follow
  task automatic hold_index(input logic v);
    @(negedge clock);
    index_inc_disable = v;
  endtask : hold_index

  // Fetch one byte; ok stays low if no answer came
  task automatic get_byte(output logic [7:0] d, output bit ok);
    @(negedge clock);
    byte_read = 1'b1;
    @(negedge clock);
    byte_read = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    // Bounded wait for the read strobe
    for (int i = 0; i < 4 && !ok; i++)
    begin
      if (read_valid === 1'b1)
      begin
        ok = 1'b1;
        d = read_data;
      end
      else
        @(negedge clock);
    end
  endtask : get_byte
endmodule : host_serial_model

// >>> gamma_table_access_test.sv
// Self-checking testbench for the gamma table access block
`timescale 1ns/1ps
module gamma_table_access_test;
  import gamma_pkg::*;
  logic clock = 1'b0; // Register clock
  logic resetn = 1'b0; // Reset, active low
  logic xfer_start, byte_write, byte_read, index_inc_disable, read_valid; // Serial port
  logic [7:0] xfer_index, write_data, read_data; // Serial port data
  logic pix_valid = 1'b0; // Pixel strobe
  logic [7:0] pix_red = 8'h00, pix_green = 8'h00, pix_blue = 8'h00; // Pixels in
  logic pix_out_valid; // Corrected strobe
  logic [7:0] pix_out_red, pix_out_green, pix_out_blue; // Pixels out
  int errors = 0; // Mismatch count
  int compares = 0; // Comparison count
  logic [7:0] d; // Read byte
  bit ok; // Read answered

  // 200 MHz clock
  always #2.5 clock = ~clock;

  gamma_table_access i_gamma_table_access
  (
    .clock(clock), .resetn(resetn), .xfer_start(xfer_start), .xfer_index(xfer_index),
    .byte_write(byte_write), .byte_read(byte_read), .write_data(write_data),
    .index_inc_disable(index_inc_disable), .read_data(read_data), .read_valid(read_valid),
    .pix_valid(pix_valid), .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue),
    .pix_out_valid(pix_out_valid), .pix_out_red(pix_out_red),
    .pix_out_green(pix_out_green), .pix_out_blue(pix_out_blue)
  );

  host_serial_model i_host_serial_model
  (
    .clock(clock), .xfer_start(xfer_start), .xfer_index(xfer_index), .byte_write(byte_write),
    .byte_read(byte_read), .write_data(write_data), .index_inc_disable(index_inc_disable),
    .read_data(read_data), .read_valid(read_valid)
  );

  // Print the counts and the verdict, then stop
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // Compare one byte
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Drive one pixel and compare the corrected outputs one cycle later
  task automatic pixel(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b,
                       input logic [7:0] er, input logic [7:0] eg, input logic [7:0] eb);
    @(negedge clock);
    pix_valid = 1'b1;
    pix_red = r;
    pix_green = g;
    pix_blue = b;
    @(negedge clock);
    pix_valid = 1'b0;
    check("pix valid", 8'h01, {7'h00, pix_out_valid});
    check("pix red", er, pix_out_red);
    check("pix green", eg, pix_out_green);
    check("pix blue", eb, pix_out_blue);
  endtask : pixel

  // Fetch a byte at the current index, stopping the run if it never answers
  task automatic fetch(output logic [7:0] v);
    i_host_serial_model.get_byte(v, ok);
    if (!ok)
    begin
      errors++;
      $display("[ERR] read_valid expected 1 seen 0");
      finish_test();
    end
  endtask : fetch

  // Single register write and read
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] v);
    i_host_serial_model.open_xfer(idx);
    i_host_serial_model.send_byte(v);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] v);
    i_host_serial_model.open_xfer(idx);
    fetch(v);
  endtask : rd_reg

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    // Values after reset
    rd_reg(8'hf0, d); check("control", CTRL_RESET, d);
    rd_reg(8'hf1, d); check("address", TADDR_RESET, d);
    rd_reg(8'hff, d); check("page", 8'h00, d);
    // Stream two bytes into all tables with a fixed index
    wr_reg(8'hf0, {4'h0, INC_WRITE, SEL_RGB});
    wr_reg(8'hf1, 8'h10);
    i_host_serial_model.open_xfer(8'hf2);
    i_host_serial_model.send_byte(8'ha5);
    i_host_serial_model.send_byte(8'h5a);
    rd_reg(8'hf1, d); check("address", 8'h12, d);
    // Each colour table holds the bytes sent through the RGB set
    for (int s = 1; s < 4; s++)
    begin
      wr_reg(8'hf0, {4'h0, INC_READ, s[1:0]});
      wr_reg(8'hf1, 8'h10);
      i_host_serial_model.open_xfer(8'hf2);
      fetch(d); check("entry", 8'ha5, d);
      fetch(d); check("entry", 8'h5a, d);
    end
    // Every increment mode, one write then one read
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(8'hf0, {4'h0, m[1:0], SEL_RED});
      wr_reg(8'hf1, 8'h20);
      i_host_serial_model.open_xfer(8'hf2);
      i_host_serial_model.send_byte(8'h77);
      fetch(d);
      if (!m[1])
        check("entry", 8'h77, d);
      rd_reg(8'hf1, d); check("address", 8'h20 + m[1] + m[0], d);
    end
    // Index advances across control, address and data in one transfer
    i_host_serial_model.hold_index(1'b0);
    i_host_serial_model.open_xfer(8'hf0);
    i_host_serial_model.send_byte({3'b100, 1'b0, INC_NONE, SEL_RED});
    i_host_serial_model.send_byte(8'h40);
    i_host_serial_model.send_byte(8'h3c);
    i_host_serial_model.hold_index(1'b1);
    rd_reg(8'hf2, d); check("entry", 8'h3c, d);
    rd_reg(8'hf1, d); check("address", 8'h40, d);
    // Upper page hides the gamma registers
    wr_reg(8'hff, 8'h01);
    rd_reg(8'hf0, d); check("upper control", UNMAPPED_READ, d);
    wr_reg(8'hf0, 8'hff);
    rd_reg(8'hff, d); check("page", 8'h01, d);
    wr_reg(8'hff, 8'h00);
    rd_reg(8'hf0, d); check("control", 8'h81, d);
    // Only red is corrected through its table
    pixel(8'h40, 8'h40, 8'h40, 8'h3c, 8'h40, 8'h40);
    // All three corrections on, each colour through its own table
    wr_reg(8'hf0, 8'he0);
    pixel(8'h10, 8'h11, 8'h10, 8'ha5, 8'h5a, 8'ha5);
    // Reset in mid-run clears control, address and page again
    wr_reg(8'hff, 8'h01);
    @(negedge clock);
    resetn = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    rd_reg(8'hff, d); check("page", 8'h00, d);
    rd_reg(8'hf0, d); check("control", CTRL_RESET, d);
    rd_reg(8'hf1, d); check("address", TADDR_RESET, d);
    finish_test();
  end
endmodule : gamma_table_access_test
